/* File: rtl/gpfl_panel.v */
// supervisory fault logic of a generator control panel
// Overview of operation
// - fault inputs default normally closed, polarity selectable
// - coolant fault after 100ms, clears at once
// - water-leak fault after 100ms, clears at once
// - alternate leak mode: yellow warning, no shutdown
// - oil-pressure fault after 1s, clears at once
// - charge good level selectable, red/green lamps
// - excitation with panel or pump, 12V only
// - AC good when switch pulls low, lamps
// - pre-glow follows heat button
// - optionally start button also drives pre-glow
// - fuel pump only without shutdown fault
// - held start button overrides the shutdown on the fuel pump
// - starter follows start button
// - winding fault after 100ms, selectable polarity
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "gpfl_regs.vh"
module gpfl_panel #(
	parameter TICK_CYCLES = `GPFL_TICK_CYCLES // cycles per millisecond tick
) (
	input  wire        mclk,                 // 100 MHz system clock
	input  wire        rst_n,                // async reset, active low
	input  wire [3:0]  addr,                 // register byte address
	input  wire [31:0] wdata,                // register write data
	input  wire        wr,                   // write strobe
	input  wire        rd,                   // read strobe
	output reg  [31:0] rdata,                // read data, cycle after rd
	input  wire        coolant_closed_in,    // coolant switch contact closed
	input  wire        leak_closed_in,       // water-leak switch contact closed
	input  wire        oil_closed_in,        // oil pressure switch contact closed
	input  wire        winding_closed_in,    // winding switch contact closed
	input  wire        charge_monitor_in,    // charge indicator level
	output wire        charge_monitor_out,   // excitation drive level
	output reg         charge_monitor_oe,    // excitation drive enable
	input  wire        ac_voltage_good_in_n, // AC status, low when good
	input  wire        heat_btn,             // heat push button held
	input  wire        start_btn,            // start push button held
	input  wire        on_btn,               // panel on push button
	input  wire        off_btn,              // panel off push button
	output reg         glow_out,             // pre-glow relay
	output reg         starter_out,          // starter relay
	output reg         fuel_pump_out,        // fuel pump relay
	output reg         coolant_lamp_red,     // coolant fault lamp
	output reg         leak_lamp_red,        // water-leak fault lamp
	output reg         leak_lamp_yellow,     // leak warning lamp
	output reg         oil_lamp_red,         // oil pressure fault lamp
	output reg         winding_lamp_red,     // winding fault lamp
	output reg         charge_lamp_red,      // charge fault lamp
	output reg         charge_lamp_green,    // charge good lamp
	output reg         ac_lamp_red,          // AC fault lamp
	output reg         ac_lamp_green,        // AC good lamp
	output reg         heat_lamp,            // pre-glow active lamp
	output reg         start_lamp,           // starter active lamp
	output reg         standby_lamp          // panel on lamp
);

	localparam integer TICK_SPAN = TICK_CYCLES - 1;
	// the timebase counter is 17 bits, enough for the 100000 cycles of a millisecond
	localparam [16:0]  TICK_LAST = TICK_SPAN[16:0];

	// ==========================================================
	// helpers
	// normally closed: an open contact is a fault; normally open: a closed one
	function fault_of;
		input closed;
		input no_mode;
		begin
			fault_of = no_mode ? closed : ~closed;
		end
	endfunction

	function reg_hit;
		input [3:0] a;
		input [3:0] ofs;
		begin
			reg_hit = (a == ofs);
		end
	endfunction

	// ==========================================================
	// state
	reg [`GPFL_CFG_W-1:0]  cfg_reg;
	reg [`GPFL_HIST_W-1:0] hist_reg;
	reg [`GPFL_HIST_W-1:0] prev_reg;
	reg [16:0]             tick_cnt_reg;
	reg                    tick_reg;
	reg                    panel_on_reg;
	reg                    excite_reg;

	wire cool_raw;
	wire leak_raw;
	wire oil_raw;
	wire wind_raw;
	wire cool_flt;
	wire leak_flt;
	wire oil_flt;
	wire wind_flt;
	wire leak_alt;
	wire leak_shut;
	wire leak_warn;
	wire shutdown;
	wire charge_good;
	wire ac_good;
	wire glow_next;
	wire pump_next;
	wire excite_next;
	wire starter_next;
	wire tick_wrap;
	wire cfg_we;
	wire hist_clr;
	wire [`GPFL_HIST_W-1:0]  ev_now;
	wire [`GPFL_HIST_W-1:0]  ev_rise;
	wire [`GPFL_ST_W-1:0]    status;

	// ==========================================================
	// millisecond timebase
	// free running, so the first tick seen by a new fault may come early
	assign tick_wrap = (tick_cnt_reg == TICK_LAST);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt_reg <= 17'h0_0000;
			tick_reg     <= 1'b0;
		end else if (tick_wrap) begin
			tick_cnt_reg <= 17'h0_0000;
			tick_reg     <= 1'b1;
		end else begin
			tick_cnt_reg <= tick_cnt_reg + 17'h0_0001;
			tick_reg     <= 1'b0;
		end
	end

	// ==========================================================
	// fault inputs and persistence
	assign cool_raw = fault_of(coolant_closed_in, cfg_reg[`GPFL_CFG_COOL_NO]);
	assign leak_raw = fault_of(leak_closed_in, cfg_reg[`GPFL_CFG_LEAK_NO]);
	assign oil_raw  = fault_of(oil_closed_in, cfg_reg[`GPFL_CFG_OIL_NO]);
	assign wind_raw = fault_of(winding_closed_in, cfg_reg[`GPFL_CFG_WIND_NO]);

	gpfl_persist u_cool (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (tick_reg),
		.fault_raw (cool_raw),
		.limit     (`GPFL_TEMP_MS),
		.fault_reg (cool_flt)
	);

	gpfl_persist u_leak (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (tick_reg),
		.fault_raw (leak_raw),
		.limit     (`GPFL_TEMP_MS),
		.fault_reg (leak_flt)
	);

	gpfl_persist u_oil (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (tick_reg),
		.fault_raw (oil_raw),
		.limit     (`GPFL_OIL_MS),
		.fault_reg (oil_flt)
	);

	gpfl_persist u_wind (
		.mclk      (mclk),
		.rst_n     (rst_n),
		.tick      (tick_reg),
		.fault_raw (wind_raw),
		.limit     (`GPFL_TEMP_MS),
		.fault_reg (wind_flt)
	);

	// ==========================================================
	// fault classes
	assign leak_alt  = cfg_reg[`GPFL_CFG_LEAK_ALT];
	assign leak_shut = leak_flt & ~leak_alt;
	assign leak_warn = leak_flt & leak_alt;
	assign shutdown  = cool_flt | leak_shut | oil_flt | wind_flt;

	// charge and AC status are shown as they are, without persistence
	assign charge_good = (charge_monitor_in == cfg_reg[`GPFL_CFG_CHG_HIGH]);
	assign ac_good     = ~ac_voltage_good_in_n;

	// ==========================================================
	// panel on/off; off wins when both buttons are pressed
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			panel_on_reg <= 1'b0;
		end else if (off_btn) begin
			panel_on_reg <= 1'b0;
		end else if (on_btn) begin
			panel_on_reg <= 1'b1;
		end
	end

	// ==========================================================
	// relay outputs, all gated by the panel being on
	assign glow_next = panel_on_reg & (heat_btn |
		(start_btn & cfg_reg[`GPFL_CFG_START_GLW]));
	// start held keeps the pump on through a shutdown so a cold engine can crank past faults
	assign pump_next = panel_on_reg & (start_btn | ~shutdown);
	assign excite_next = cfg_reg[`GPFL_CFG_V12] & panel_on_reg &
		(cfg_reg[`GPFL_CFG_EXC_PUMP] ? pump_next : 1'b1);
	// starter relay and its lamp share one term so they never disagree
	assign starter_next = panel_on_reg & start_btn;


	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			glow_out      <= 1'b0;
			starter_out   <= 1'b0;
			fuel_pump_out <= 1'b0;
			excite_reg    <= 1'b0;
		end else begin
			glow_out      <= glow_next;
			starter_out   <= starter_next;
			fuel_pump_out <= pump_next;
			excite_reg    <= excite_next;
		end
	end

	// excitation is a high drive into the dynamo field only while enabled
	assign charge_monitor_out = 1'b1;
	always @* begin
		charge_monitor_oe = excite_reg;
	end

	// ==========================================================
	// lamps
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			coolant_lamp_red  <= 1'b0;
			leak_lamp_red     <= 1'b0;
			leak_lamp_yellow  <= 1'b0;
			oil_lamp_red      <= 1'b0;
			winding_lamp_red  <= 1'b0;
			charge_lamp_red   <= 1'b0;
			charge_lamp_green <= 1'b0;
			ac_lamp_red       <= 1'b0;
			ac_lamp_green     <= 1'b0;
			heat_lamp         <= 1'b0;
			start_lamp        <= 1'b0;
			standby_lamp      <= 1'b0;
		end else begin
			coolant_lamp_red  <= cool_flt;
			leak_lamp_red     <= leak_shut;
			leak_lamp_yellow  <= leak_warn;
			oil_lamp_red      <= oil_flt;
			winding_lamp_red  <= wind_flt;
			charge_lamp_red   <= ~charge_good;
			charge_lamp_green <= charge_good;
			ac_lamp_red       <= ~ac_good;
			ac_lamp_green     <= ac_good;
			heat_lamp         <= glow_next;
			start_lamp        <= starter_next;
			standby_lamp      <= panel_on_reg;
		end
	end

	// ==========================================================
	// fault event history
	assign ev_now[`GPFL_ST_COOL]      = cool_flt;
	assign ev_now[`GPFL_ST_LEAK]      = leak_shut;
	assign ev_now[`GPFL_ST_LEAK_WARN] = leak_warn;
	assign ev_now[`GPFL_ST_OIL]       = oil_flt;
	assign ev_now[`GPFL_ST_WIND]      = wind_flt;
	assign hist_clr = wr && reg_hit(addr, `GPFL_HIST_OFS);
	assign ev_rise = ev_now & ~prev_reg;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			prev_reg <= {`GPFL_HIST_W{1'b0}};
			hist_reg <= {`GPFL_HIST_W{1'b0}};
		end else begin
			prev_reg <= ev_now;
			// a new event in the clearing cycle survives the clear
			if (hist_clr) begin
				hist_reg <= (hist_reg & ~wdata[`GPFL_HIST_W-1:0]) | ev_rise;
			end else begin
				hist_reg <= hist_reg | ev_rise;
			end
		end
	end

	// ==========================================================
	// configuration register
	// writes to status and identity decode nowhere and are dropped
	assign cfg_we = wr && reg_hit(addr, `GPFL_CFG_OFS);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_reg <= `GPFL_CFG_RST;
		end else if (cfg_we) begin
			cfg_reg <= wdata[`GPFL_CFG_W-1:0];
		end
	end

	// ==========================================================
	// status and read port
	// one bit to a line keeps the field positions tied to the header
	assign status[`GPFL_ST_COOL]      = cool_flt;
	assign status[`GPFL_ST_LEAK]      = leak_shut;
	assign status[`GPFL_ST_LEAK_WARN] = leak_warn;
	assign status[`GPFL_ST_OIL]       = oil_flt;
	assign status[`GPFL_ST_WIND]      = wind_flt;
	assign status[`GPFL_ST_CHG_GOOD]  = charge_good;
	assign status[`GPFL_ST_AC_GOOD]   = ac_good;
	assign status[`GPFL_ST_PANEL_ON]  = panel_on_reg;
	assign status[`GPFL_ST_GLOW]      = glow_out;
	assign status[`GPFL_ST_STARTER]   = starter_out;
	assign status[`GPFL_ST_PUMP]      = fuel_pump_out;
	assign status[`GPFL_ST_EXCITE]    = excite_reg;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
				`GPFL_CFG_OFS: begin
					rdata <= {{(32-`GPFL_CFG_W){1'b0}}, cfg_reg};
				end
				`GPFL_STAT_OFS: begin
					rdata <= {{(32-`GPFL_ST_W){1'b0}}, status};
				end
				`GPFL_HIST_OFS: begin
					rdata <= {{(32-`GPFL_HIST_W){1'b0}}, hist_reg};
				end
				`GPFL_ID_OFS: begin
					rdata <= `GPFL_ID_VALUE;
				end
				default: begin
					rdata <= 32'h0000_0000;
				end
			endcase
		end else begin
			rdata <= 32'h0000_0000;
		end
	end

endmodule // gpfl_panel

/* File: rtl/gpfl_regs.vh */
// register map, field positions, reset values and timing constants of the panel fault logic
`ifndef GPFL_REGS_VH
`define GPFL_REGS_VH

// ==========================================================
// timing
`define GPFL_CLK_NS        10
`define GPFL_TICK_NS       1000000
`define GPFL_TICK_CYCLES   (`GPFL_TICK_NS / `GPFL_CLK_NS)
`define GPFL_TEMP_MS       10'h064
`define GPFL_OIL_MS        10'h3E8

// ==========================================================
// register offsets (byte addresses)
`define GPFL_CFG_OFS       4'h0
`define GPFL_STAT_OFS      4'h4
`define GPFL_HIST_OFS      4'h8
`define GPFL_ID_OFS        4'hC

// ==========================================================
// configuration fields
`define GPFL_CFG_COOL_NO   0
`define GPFL_CFG_LEAK_NO   1
`define GPFL_CFG_OIL_NO    2
`define GPFL_CFG_WIND_NO   3
`define GPFL_CFG_LEAK_ALT  4
`define GPFL_CFG_CHG_HIGH  5
`define GPFL_CFG_EXC_PUMP  6
`define GPFL_CFG_START_GLW 7
`define GPFL_CFG_V12       8
`define GPFL_CFG_W         9
`define GPFL_CFG_RST       9'h100

// ==========================================================
// status fields
`define GPFL_ST_COOL       0
`define GPFL_ST_LEAK       1
`define GPFL_ST_LEAK_WARN  2
`define GPFL_ST_OIL        3
`define GPFL_ST_WIND       4
`define GPFL_ST_CHG_GOOD   5
`define GPFL_ST_AC_GOOD    6
`define GPFL_ST_PANEL_ON   7
`define GPFL_ST_GLOW       8
`define GPFL_ST_STARTER    9
`define GPFL_ST_PUMP       10
`define GPFL_ST_EXCITE     11
`define GPFL_ST_W          12

// ==========================================================
// event history: bits 0..4 follow the fault fields of status
`define GPFL_HIST_W        5

// identity word, value arbitrary
`define GPFL_ID_VALUE      32'h0A5C_0001

`endif

/* File: rtl/gpfl_persist.v */
// persistence filter: a fault shows only after it has held for a number of timebase ticks
`timescale 1ns/1ps
module gpfl_persist (
	input  wire       mclk,      // system clock
	input  wire       rst_n,     // async reset, active low
	input  wire       tick,      // one-cycle timebase pulse
	input  wire       fault_raw, // unfiltered fault condition
	input  wire [9:0] limit,     // persistence in ticks
	output reg        fault_reg  // filtered fault
);

	reg [9:0] cnt_reg;

	// ==========================================================
	// counter, cleared at once when the fault goes away
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg   <= 10'h000;
			fault_reg <= 1'b0;
		end else if (!fault_raw) begin
			cnt_reg   <= 10'h000;
			fault_reg <= 1'b0;
		end else begin
			if (tick && (cnt_reg != limit)) begin
				cnt_reg <= cnt_reg + 10'h001;
			end
			// first tick may come early, so persistence is between limit-1 and limit ms
			fault_reg <= (cnt_reg == limit);
		end
	end

endmodule // gpfl_persist

/* File: verif/gpfl_plant.sv */
// far-side model: fault switches to ground, ac sensor, dynamo on the charge pin
`timescale 1ns/1ps
module gpfl_plant (
	input  wire       mclk,    // clock, unused by the switches
	input  wire [3:0] fault,   // engine faults present
	input  wire [3:0] no_mode, // switch is normally open
	input  wire       ac_bad,  // generator ac missing
	input  wire       dyn_ok,  // dynamo charging
	input  wire       hi_good, // dynamo shows good as high
	input  wire       exc_oe,  // panel drives the charge pin
	input  wire       exc_lvl, // panel drive level
	output wire [3:0] closed,  // contact closed to ground
	output wire       ac_n,    // open collector, pulled up
	output wire       chg_pin  // resolved charge pin level
);
	// a normally closed switch opens on a fault
	assign closed  = fault ^ ~no_mode;
	// the pull-up wins while the sensor switch is open
	assign ac_n    = ac_bad;
	assign chg_pin = exc_oe ? exc_lvl : (dyn_ok ~^ hi_good);
endmodule // gpfl_plant

/* File: verif/gpfl_chk_asserts.sv */
// assertion checker on the panel fault logic ports
`timescale 1ns/1ps
module gpfl_chk (
	input wire        mclk, // clock
	input wire        rst_n, // reset
	input wire        rd, // read strobe
	input wire [31:0] rdata, // read data
	input wire        coolant_closed_in, // contact
	input wire        oil_closed_in, // contact
	input wire        ac_voltage_good_in_n, // ac status
	input wire        heat_btn, // button
	input wire        start_btn, // button
	input wire        off_btn, // button
	input wire        glow_out, // relay
	input wire        starter_out, // relay
	input wire        fuel_pump_out, // relay
	input wire        coolant_lamp_red, // lamp
	input wire        oil_lamp_red, // lamp
	input wire        ac_lamp_red, // lamp
	input wire        ac_lamp_green, // lamp
	input wire        standby_lamp // lamp
);
	reg        off_q_reg;
	reg        cool_q_reg;
	reg        oil_q_reg;
	reg [15:0] cool_age_reg;
	reg [15:0] oil_age_reg;
	wire       run_ok = standby_lamp && !off_btn && !off_q_reg;
	// ========
	// age of the coolant and oil contact levels; their fault lamps may not rise on a young level
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			off_q_reg    <= 1'b0;
			cool_q_reg   <= 1'b0;
			oil_q_reg    <= 1'b0;
			cool_age_reg <= 16'h0000;
			oil_age_reg  <= 16'h0000;
		end else begin
			off_q_reg    <= off_btn;
			cool_q_reg   <= coolant_closed_in;
			oil_q_reg    <= oil_closed_in;
			cool_age_reg <= (coolant_closed_in != cool_q_reg) ? 16'h0000 :
				cool_age_reg + {15'h0000, ~&cool_age_reg};
			oil_age_reg  <= (oil_closed_in != oil_q_reg) ? 16'h0000 :
				oil_age_reg + {15'h0000, ~&oil_age_reg};
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// ========
	// properties
	property p_glow_on; heat_btn && run_ok |=> glow_out; endproperty
	a_glow_on: assert property (p_glow_on) else $error("glow missing");
	property p_glow_off; !heat_btn && !start_btn |=> !glow_out; endproperty
	a_glow_off: assert property (p_glow_off) else $error("glow stuck");
	property p_start; start_btn && run_ok |=> starter_out && fuel_pump_out; endproperty
	a_start: assert property (p_start) else $error("start relays");
	property p_start_off; !start_btn |=> !starter_out; endproperty
	a_start_off: assert property (p_start_off) else $error("starter stuck");
	property p_cool_age; $rose(coolant_lamp_red) |-> cool_age_reg > 16'h0384; endproperty
	a_cool_age: assert property (p_cool_age) else $error("coolant early");
	property p_oil_age; $rose(oil_lamp_red) |-> oil_age_reg > 16'h2328; endproperty
	a_oil_age: assert property (p_oil_age) else $error("oil early");
	property p_ac_good; !ac_voltage_good_in_n [*2] |-> ac_lamp_green && !ac_lamp_red; endproperty
	a_ac_good: assert property (p_ac_good) else $error("ac good lamps");
	property p_ac_bad; ac_voltage_good_in_n [*2] |-> ac_lamp_red && !ac_lamp_green; endproperty
	a_ac_bad: assert property (p_ac_bad) else $error("ac fault lamps");
	property p_rd_idle; !$past(rd) |-> rdata == 32'h0000_0000; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // gpfl_chk
bind gpfl_panel gpfl_chk u_chk (.mclk(mclk), .rst_n(rst_n), .rd(rd), .rdata(rdata),
	.coolant_closed_in(coolant_closed_in), .oil_closed_in(oil_closed_in),
	.ac_voltage_good_in_n(ac_voltage_good_in_n), .heat_btn(heat_btn), .start_btn(start_btn),
	.off_btn(off_btn), .glow_out(glow_out), .starter_out(starter_out),
	.fuel_pump_out(fuel_pump_out), .coolant_lamp_red(coolant_lamp_red),
	.oil_lamp_red(oil_lamp_red), .ac_lamp_red(ac_lamp_red), .ac_lamp_green(ac_lamp_green),
	.standby_lamp(standby_lamp));

/* File: verif/tb_generator_panel_fault_logic.sv */
// self-checking bench for the panel fault logic
`timescale 1ns/1ps
`include "gpfl_regs.vh"
module tb_generator_panel_fault_logic;
	logic        mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
	logic        heat_btn = 1'b0, start_btn = 1'b0, on_btn = 1'b0, off_btn = 1'b0;
	logic        ac_bad = 1'b0, dyn_ok = 1'b1, hi_good = 1'b0;
	logic [3:0]  addr = 4'h0, flt = 4'h0, nom = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	wire  [31:0] rdata;
	wire  [3:0]  closed, lamp;
	wire         chg_pin, chg_out, chg_oe, ac_n, glow_out, starter_out, fuel_pump_out;
	wire         lamp_yel, chg_red, chg_grn, ac_red, ac_grn, standby_lamp, heat_lmp, start_lmp;
	integer      n_fail = 0, total_checks = 0, i;
	always #5 mclk = ~mclk;
	gpfl_plant u_plant (.mclk(mclk), .fault(flt), .no_mode(nom), .ac_bad(ac_bad),
		.dyn_ok(dyn_ok), .hi_good(hi_good), .exc_oe(chg_oe), .exc_lvl(chg_out),
		.closed(closed), .ac_n(ac_n), .chg_pin(chg_pin));
	// short tick keeps the one second filter at ten thousand cycles
	gpfl_panel #(.TICK_CYCLES(10)) DUT (.mclk(mclk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .coolant_closed_in(closed[0]),
		.leak_closed_in(closed[1]), .oil_closed_in(closed[2]), .winding_closed_in(closed[3]),
		.charge_monitor_in(chg_pin), .charge_monitor_out(chg_out), .charge_monitor_oe(chg_oe),
		.ac_voltage_good_in_n(ac_n), .heat_btn(heat_btn), .start_btn(start_btn),
		.on_btn(on_btn), .off_btn(off_btn), .glow_out(glow_out), .starter_out(starter_out),
		.fuel_pump_out(fuel_pump_out), .coolant_lamp_red(lamp[0]), .leak_lamp_red(lamp[1]),
		.leak_lamp_yellow(lamp_yel), .oil_lamp_red(lamp[2]), .winding_lamp_red(lamp[3]),
		.charge_lamp_red(chg_red), .charge_lamp_green(chg_grn), .ac_lamp_red(ac_red),
		.ac_lamp_green(ac_grn), .heat_lamp(heat_lmp), .start_lamp(start_lmp),
		.standby_lamp(standby_lamp));
	// ========
	// tasks
	task chk(input [31:0] got, input [31:0] exp);
		total_checks = total_checks + 1;
		if (got !== exp) begin
			n_fail = n_fail + 1;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wt(input integer n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wr_reg(input [3:0] a, input [31:0] d);
		@(posedge mclk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	task rd_reg(input [3:0] a, input [31:0] exp);
		@(posedge mclk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	// the fault must stay hidden up to two ticks short of its delay
	task tfault(input integer k, input integer ms);
		@(posedge mclk);
		flt[k] <= 1'b1;
		wt(ms * 10 - 20);
		chk(lamp[k], 1'b0);
		wt(30);
		chk(lamp[k], 1'b1);
		wt(2);
		chk({fuel_pump_out, chg_oe}, 2'h0);
		@(posedge mclk);
		start_btn <= 1'b1;
		wt(2);
		chk({fuel_pump_out, glow_out}, 2'h3);
		@(posedge mclk);
		start_btn <= 1'b0;
		flt[k]    <= 1'b0;
		wt(3);
		chk(lamp[k], 1'b0);
		wt(2);
		chk(fuel_pump_out, 1'b1);
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge mclk);
		n_fail = n_fail + 1;
		close_out;
	end
	// ========
	// main sequence
	initial begin
		repeat (20) @(posedge mclk);
		rst_n <= 1'b1;
		rd_reg(`GPFL_CFG_OFS, 32'h0000_0100);
		rd_reg(`GPFL_ID_OFS, `GPFL_ID_VALUE);
		rd_reg(4'h2, 32'h0000_0000);
		chk({ac_grn, ac_red, chg_grn, chg_red}, 4'hA);
		@(posedge mclk);
		ac_bad  <= 1'b1;
		hi_good <= 1'b1;
		wt(3);
		chk({ac_grn, ac_red, chg_grn, chg_red}, 4'h5);
		wr_reg(`GPFL_CFG_OFS, 32'h0000_0120);
		@(posedge mclk);
		ac_bad   <= 1'b0;
		heat_btn <= 1'b1;
		wt(3);
		chk({chg_grn, chg_red, glow_out, chg_oe}, 4'h8);
		@(posedge mclk);
		heat_btn <= 1'b0;
		on_btn   <= 1'b1;
		@(posedge mclk);
		on_btn <= 1'b0;
		wt(3);
		chk({standby_lamp, chg_oe, glow_out, chg_out}, 4'hD);
		@(posedge mclk);
		heat_btn <= 1'b1;
		wt(2);
		chk({glow_out, heat_lmp}, 2'h3);
		@(posedge mclk);
		heat_btn  <= 1'b0;
		start_btn <= 1'b1;
		wt(2);
		chk({glow_out, starter_out, fuel_pump_out, start_lmp}, 4'h7);
		wr_reg(`GPFL_CFG_OFS, 32'h0000_01C0);
		wt(2);
		chk({glow_out, chg_oe}, 2'h3);
		@(posedge mclk);
		start_btn <= 1'b0;
		wt(2);
		chk({glow_out, starter_out, fuel_pump_out, heat_lmp, start_lmp}, 5'h04);
		for (i = 0; i < 4; i = i + 1)
			tfault(i, (i == 2) ? 1000 : 100);
		wr_reg(`GPFL_CFG_OFS, 32'h0000_01C1);
		@(posedge mclk);
		nom[0] <= 1'b1;
		tfault(0, 100);
		// all inputs normally open from here on
		wr_reg(`GPFL_CFG_OFS, 32'h0000_01CF);
		@(posedge mclk);
		nom <= 4'hF;
		tfault(1, 100);
		tfault(3, 100);
		wr_reg(`GPFL_CFG_OFS, 32'h0000_01DF);
		@(posedge mclk);
		flt[1] <= 1'b1;
		wt(1010);
		chk({lamp_yel, lamp[1], fuel_pump_out}, 3'h5);
		rd_reg(`GPFL_STAT_OFS, 32'h0000_0CC4);
		wr_reg(`GPFL_CFG_OFS, 32'h0000_00DF);
		wt(2);
		chk({fuel_pump_out, chg_oe}, 2'h2);
		@(posedge mclk);
		off_btn <= 1'b1;
		@(posedge mclk);
		off_btn <= 1'b0;
		wt(3);
		chk({standby_lamp, fuel_pump_out}, 2'h0);
		// every fault class has risen once; clear two of them by writing ones
		rd_reg(`GPFL_HIST_OFS, 32'h0000_001F);
		wr_reg(`GPFL_HIST_OFS, 32'h0000_0003);
		rd_reg(`GPFL_HIST_OFS, 32'h0000_001C);
		wr_reg(`GPFL_STAT_OFS, 32'h0000_0FFF);
		rd_reg(`GPFL_STAT_OFS, 32'h0000_0044);
		close_out;
	end
endmodule // tb_generator_panel_fault_logic
